// file: src/irq_bank_pkg.sv
// Constants, layouts and types of the peripheral interrupt flag bank
package irq_bank_pkg;

  // Register byte offsets
  localparam logic [11:0] OFF_ENABLE_3  = 12'h000;
  localparam logic [11:0] OFF_ENABLE_4  = 12'h004;
  localparam logic [11:0] OFF_REQUEST_0 = 12'h008;
  localparam logic [11:0] OFF_REQUEST_1 = 12'h00C;
  localparam logic [11:0] OFF_CONTROL   = 12'h010;

  // Reset values
  localparam logic [7:0] RST_ENABLE  = 8'h00;
  localparam logic [7:0] RST_REQUEST = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;

  // Field positions
  localparam int unsigned BIT_GLOBAL_IRQ_EN    = 7;
  localparam int unsigned BIT_PERIPH_IRQ_EN    = 6;
  localparam int unsigned BIT_TIMER0_OVF       = 5;
  localparam int unsigned BIT_PIN_CHANGE       = 4;
  localparam int unsigned BIT_EXT_PIN          = 0;
  localparam int unsigned BIT_TIMER1_GATE      = 7;
  localparam int unsigned BIT_ADC_DONE         = 6;
  localparam int unsigned BIT_UART_RX_NONEMPTY = 5;
  localparam int unsigned BIT_UART_TX_EMPTY    = 4;
  localparam int unsigned BIT_SYNC_DONE        = 3;
  localparam int unsigned BIT_SYNC_COLLISION   = 2;
  localparam int unsigned BIT_TIMER2_MATCH     = 1;
  localparam int unsigned BIT_TIMER1_OVF       = 0;

  // Bits software may write in each flag register
  localparam logic [7:0] REQ0_WR_MASK = 8'h21;
  localparam logic [7:0] REQ1_WR_MASK = 8'hCF;
  localparam logic [7:0] CTRL_WR_MASK = 8'hC0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic osc_fail_irq_en;
    logic clk_switch_done_irq_en;
    logic timer3_gate_irq_en;
    logic timer3_ovf_irq_en;
    logic logic_cell4_irq_en;
    logic logic_cell3_irq_en;
    logic logic_cell2_irq_en;
    logic logic_cell1_irq_en;
  } enable3_s;

  typedef struct packed {
    logic wavegen2_irq_en;
    logic wavegen1_irq_en;
    logic timer5_gate_irq_en;
    logic timer5_ovf_irq_en;
    logic capcomp4_irq_en;
    logic capcomp3_irq_en;
    logic capcomp2_irq_en;
    logic capcomp1_irq_en;
  } enable4_s;

  // One-cycle event strobes from on-chip sources
  typedef struct packed {
    logic timer0_ovf;
    logic ext_pin;
  } req0_evt_s;

  typedef struct packed {
    logic timer1_gate_close;
    logic adc_done;
    logic sync_serial_done;
    logic sync_serial_collision;
    logic timer2_period_match;
    logic timer1_ovf;
  } req1_evt_s;

endpackage

// file: src/peripheral_irq_enable_flag_bank.sv
// Peripheral interrupt enable and request flag bank, AXI4-Lite slave
// Contract
// - Flags set on their source event whatever the enables hold.
// - Enable register 3 holds osc-fail down to logic cell 1 enables.
// - Enable register 4 holds wavegen 2 down to capture/compare 1.
// - Enable bits are read/write; 1 allows, 0 blocks the source.
// - All enable and flag bits reset to zero on any reset.
// - Request 0 bits 7-6 and 3-1 read zero and ignore writes.
// - Request 0 bit 5 sets on timer0 overflow, held till cleared.
// - Request 0 bit 4 is read-only OR of per-pin change flags.
// - Request 0 bit 0 sets on external pin event, held till cleared.
// - Request 1 bit 7 sets when the timer1 gate closes.
// - Request 1 bit 6 sets when an ADC conversion completes.
// - Request 1 bit 5 reads 1 while the serial receive buffer has data.
// - Request 1 bit 4 reads 1 while the serial transmit buffer is empty.
// - Request 1 bit 3 sets on sync serial completion, held till cleared.
// - Request 1 bit 2 sets on sync serial collision, held till cleared.
// - Request 1 bit 1 sets on timer2 period match, held till cleared.
// - Request 1 bit 0 sets on timer1 overflow, held till cleared.
// - Global enable must be 1 for any interrupt to reach the core.
// - Peripheral enable must be 1 for peripheral interrupts to pass.
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module peripheral_irq_enable_flag_bank #(
  parameter int unsigned ADDR_W       = 12,
  parameter int unsigned PIN_CHANGE_W = 8
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ADDR_W-1:0]         s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire irq_bank_pkg::req0_evt_s   req0_events,
  input  wire irq_bank_pkg::req1_evt_s   req1_events,
  input  wire logic [PIN_CHANGE_W-1:0]   per_pin_change_flags,
  input  wire logic                      uart_rx_nonempty_flag,
  input  wire logic                      uart_tx_empty_flag,
  input  wire logic [7:0]                request3_flags,
  input  wire logic [7:0]                request4_flags,
  input  wire logic [7:0]                enable0_bits,
  input  wire logic [7:0]                enable1_bits,
  output irq_bank_pkg::enable3_s         enable3_out,
  output irq_bank_pkg::enable4_s         enable4_out,
  output logic                           periph_irq_req
);
  import irq_bank_pkg::*;

  // Byte lane 0 merge; upper lanes carry nothing
  function automatic logic [7:0] lane0(
    input logic [7:0]  cur,
    input logic [31:0] data,
    input logic [3:0]  strb,
    input logic [7:0]  mask
  );
    logic [7:0] res;
    res = cur;
    if (strb[0]) begin
      res = (cur & ~mask) | (data[7:0] & mask);
    end
    return res;
  endfunction

  // Set wins over a software write in the same cycle
  function automatic logic sticky(
    input logic cur,
    input logic set,
    input logic wr,
    input logic wbit
  );
    logic res;
    res = wr ? wbit : cur;
    return res | set;
  endfunction

  // Register state
  enable3_s    enable3_ff;
  enable3_s    nxt_enable3;
  enable4_s    enable4_ff;
  enable4_s    nxt_enable4;
  logic [7:0]  control_ff;
  logic [7:0]  nxt_control;
  logic        timer0_ovf_flag_ff;
  logic        nxt_timer0_ovf_flag;
  logic        ext_pin_irq_flag_ff;
  logic        nxt_ext_pin_irq_flag;
  logic [7:0]  req1_ff;
  logic [7:0]  nxt_req1;
  logic        irq_ff;
  logic        nxt_irq;

  // Bus state
  logic              aw_got_ff;
  logic              nxt_aw_got;
  logic              w_got_ff;
  logic              nxt_w_got;
  logic [ADDR_W-1:0] waddr_ff;
  logic [ADDR_W-1:0] nxt_waddr;
  logic [31:0]       wdata_ff;
  logic [31:0]       nxt_wdata;
  logic [3:0]        wstrb_ff;
  logic [3:0]        nxt_wstrb;
  logic              awready_ff;
  logic              nxt_awready;
  logic              wready_ff;
  logic              nxt_wready;
  logic              bvalid_ff;
  logic              nxt_bvalid;
  logic [1:0]        bresp_ff;
  logic [1:0]        nxt_bresp;
  logic              arready_ff;
  logic              nxt_arready;
  logic              rvalid_ff;
  logic              nxt_rvalid;
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;
  logic [1:0]        rresp_ff;
  logic [1:0]        nxt_rresp;

  // Decode and readback
  logic        wr_fire;
  logic        wr_en3;
  logic        wr_en4;
  logic        wr_req0;
  logic        wr_req1;
  logic        wr_ctrl;
  logic        wr_hit;
  logic        pin_change_summary_flag;
  logic [7:0]  req0_view;
  logic [7:0]  req1_view;
  logic [7:0]  rd_byte;
  logic        rd_hit;
  logic [11:0] raddr;
  logic [11:0] waddr;
  logic [7:0]  req0_wr;

  assign raddr = 12'(s_axi_araddr);
  assign waddr = 12'(waddr_ff);

  // Summary is live, never stored
  assign pin_change_summary_flag = |per_pin_change_flags;

  always_comb begin
    req0_view = 8'h00;
    req0_view[BIT_TIMER0_OVF] = timer0_ovf_flag_ff;
    req0_view[BIT_PIN_CHANGE] = pin_change_summary_flag;
    req0_view[BIT_EXT_PIN]    = ext_pin_irq_flag_ff;
    req1_view = req1_ff;
    req1_view[BIT_UART_RX_NONEMPTY] = uart_rx_nonempty_flag;
    req1_view[BIT_UART_TX_EMPTY]    = uart_tx_empty_flag;
  end

  // Write channel: address and data taken in either order
  always_comb begin
    wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
    wr_en3  = 1'b0;
    wr_en4  = 1'b0;
    wr_req0 = 1'b0;
    wr_req1 = 1'b0;
    wr_ctrl = 1'b0;
    if (waddr == OFF_ENABLE_3) begin
      wr_en3 = wr_fire;
    end else if (waddr == OFF_ENABLE_4) begin
      wr_en4 = wr_fire;
    end else if (waddr == OFF_REQUEST_0) begin
      wr_req0 = wr_fire;
    end else if (waddr == OFF_REQUEST_1) begin
      wr_req1 = wr_fire;
    end else if (waddr == OFF_CONTROL) begin
      wr_ctrl = wr_fire;
    end
    wr_hit = wr_en3 | wr_en4 | wr_req0 | wr_req1 | wr_ctrl;
  end

  always_comb begin
    nxt_aw_got = aw_got_ff;
    nxt_w_got  = w_got_ff;
    nxt_waddr  = waddr_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb  = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_got = 1'b1;
      nxt_waddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_got = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (wr_fire) begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    // One write in flight; ready drops until the response is taken
    nxt_awready = !nxt_aw_got && !nxt_bvalid;
    nxt_wready  = !nxt_w_got && !nxt_bvalid;
  end

  // Read channel: data registered one cycle after the address
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    if (raddr == OFF_ENABLE_3) begin
      rd_byte = enable3_ff;
    end else if (raddr == OFF_ENABLE_4) begin
      rd_byte = enable4_ff;
    end else if (raddr == OFF_REQUEST_0) begin
      rd_byte = req0_view;
    end else if (raddr == OFF_REQUEST_1) begin
      rd_byte = req1_view;
    end else if (raddr == OFF_CONTROL) begin
      rd_byte = control_ff;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_comb begin
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    nxt_arready = arready_ff;
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid  = 1'b1;
      nxt_rdata   = {24'h000000, rd_byte};
      nxt_rresp   = rd_hit ? RESP_OKAY : RESP_SLVERR;
      nxt_arready = 1'b0;
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid  = 1'b0;
      nxt_arready = 1'b1;
    end else if (!rvalid_ff) begin
      nxt_arready = 1'b1;
    end
  end

  // Register file next values
  always_comb begin
    nxt_enable3 = enable3_ff;
    nxt_enable4 = enable4_ff;
    nxt_control = control_ff;
    req0_wr     = lane0(8'h00, wdata_ff, wstrb_ff, REQ0_WR_MASK);
    if (wr_en3) begin
      nxt_enable3 = lane0(enable3_ff, wdata_ff, wstrb_ff, 8'hFF);
    end
    if (wr_en4) begin
      nxt_enable4 = lane0(enable4_ff, wdata_ff, wstrb_ff, 8'hFF);
    end
    if (wr_ctrl) begin
      nxt_control = lane0(control_ff, wdata_ff, wstrb_ff, CTRL_WR_MASK);
    end
  end

  // Flags set regardless of any enable
  always_comb begin
    nxt_timer0_ovf_flag = sticky(timer0_ovf_flag_ff,
      req0_events.timer0_ovf, wr_req0 && wstrb_ff[0],
      req0_wr[BIT_TIMER0_OVF]);
    nxt_ext_pin_irq_flag = sticky(ext_pin_irq_flag_ff,
      req0_events.ext_pin, wr_req0 && wstrb_ff[0],
      req0_wr[BIT_EXT_PIN]);
    nxt_req1 = 8'h00;
    nxt_req1[BIT_TIMER1_GATE] = sticky(req1_ff[BIT_TIMER1_GATE],
      req1_events.timer1_gate_close, wr_req1 && wstrb_ff[0],
      wdata_ff[BIT_TIMER1_GATE]);
    nxt_req1[BIT_ADC_DONE] = sticky(req1_ff[BIT_ADC_DONE],
      req1_events.adc_done, wr_req1 && wstrb_ff[0],
      wdata_ff[BIT_ADC_DONE]);
    nxt_req1[BIT_SYNC_DONE] = sticky(req1_ff[BIT_SYNC_DONE],
      req1_events.sync_serial_done, wr_req1 && wstrb_ff[0],
      wdata_ff[BIT_SYNC_DONE]);
    nxt_req1[BIT_SYNC_COLLISION] = sticky(req1_ff[BIT_SYNC_COLLISION],
      req1_events.sync_serial_collision, wr_req1 && wstrb_ff[0],
      wdata_ff[BIT_SYNC_COLLISION]);
    nxt_req1[BIT_TIMER2_MATCH] = sticky(req1_ff[BIT_TIMER2_MATCH],
      req1_events.timer2_period_match, wr_req1 && wstrb_ff[0],
      wdata_ff[BIT_TIMER2_MATCH]);
    nxt_req1[BIT_TIMER1_OVF] = sticky(req1_ff[BIT_TIMER1_OVF],
      req1_events.timer1_ovf, wr_req1 && wstrb_ff[0],
      wdata_ff[BIT_TIMER1_OVF]);
  end

  // Request toward the core, one cycle behind the flags
  always_comb begin
    logic any_hit;
    any_hit = |(req0_view & enable0_bits)
            | |(req1_view & enable1_bits)
            | |(request3_flags & enable3_ff)
            | |(request4_flags & enable4_ff);
    nxt_irq = any_hit
            && control_ff[BIT_PERIPH_IRQ_EN]
            && control_ff[BIT_GLOBAL_IRQ_EN];
  end

  // Every reset clears all bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable3_ff          <= RST_ENABLE;
      enable4_ff          <= RST_ENABLE;
      control_ff          <= RST_CONTROL;
      timer0_ovf_flag_ff  <= 1'b0;
      ext_pin_irq_flag_ff <= 1'b0;
      req1_ff             <= RST_REQUEST;
      irq_ff              <= 1'b0;
    end else begin
      enable3_ff          <= nxt_enable3;
      enable4_ff          <= nxt_enable4;
      control_ff          <= nxt_control;
      timer0_ovf_flag_ff  <= nxt_timer0_ovf_flag;
      ext_pin_irq_flag_ff <= nxt_ext_pin_irq_flag;
      req1_ff             <= nxt_req1;
      irq_ff              <= nxt_irq;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      waddr_ff   <= '0;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= RESP_OKAY;
    end else begin
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      waddr_ff   <= nxt_waddr;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  assign s_axi_awready  = awready_ff;
  assign s_axi_wready   = wready_ff;
  assign s_axi_bvalid   = bvalid_ff;
  assign s_axi_bresp    = bresp_ff;
  assign s_axi_arready  = arready_ff;
  assign s_axi_rvalid   = rvalid_ff;
  assign s_axi_rdata    = rdata_ff;
  assign s_axi_rresp    = rresp_ff;
  assign enable3_out    = enable3_ff;
  assign enable4_out    = enable4_ff;
  assign periph_irq_req = irq_ff;

endmodule

`default_nettype wire

// file: verif/peripheral_irq_enable_flag_bank_assertions.sv
// Concurrent checks on the flag bank's bus and enable outputs
`timescale 1ns/100ps
`default_nettype none
module irq_bank_checker #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic [ADDR_W-1:0]       s_axi_awaddr,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic [31:0]             s_axi_wdata,
  input wire logic [3:0]              s_axi_wstrb,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic [1:0]              s_axi_bresp,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire irq_bank_pkg::enable3_s  enable3_out,
  input wire irq_bank_pkg::enable4_s  enable4_out,
  input wire logic                    periph_irq_req
);
  import irq_bank_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_en3;
    wr_taken ##0 (s_axi_awaddr == OFF_ENABLE_3 && s_axi_wstrb[0]);
  endsequence
  sequence wr_en4;
    wr_taken ##0 (s_axi_awaddr == OFF_ENABLE_4 && s_axi_wstrb[0]);
  endsequence
  // Reset itself is the cause here, so it cannot also disable the check
  a_reset_clears: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && enable3_out == 8'h00
    && enable4_out == 8'h00 && !periph_irq_req)
    else $error("outputs not cleared by reset");
  a_wr_answer: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not on the second edge");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while response pending");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read data not one edge after address");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_en3_write: assert property (wr_en3 |-> ##2
    enable3_out == 8'($past(s_axi_wdata, 2)))
    else $error("enable 3 output differs from written byte");
  a_en4_write: assert property (wr_en4 |-> ##2
    enable4_out == 8'($past(s_axi_wdata, 2)))
    else $error("enable 4 output differs from written byte");
  a_en_stable: assert property ($past(aresetn) && !$stable(enable3_out) |->
    s_axi_bvalid)
    else $error("enable 3 changed without a write");
endmodule
`default_nettype wire

// file: verif/irq_event_source_model.sv
// Event strobe sources standing in for the on-chip peripherals
`timescale 1ns/100ps
`default_nettype none
module irq_event_source_model (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          fire_req,
  output irq_bank_pkg::req0_evt_s  req0_events,
  output irq_bank_pkg::req1_evt_s  req1_events
);
  import irq_bank_pkg::*;
  logic [7:0] fire_ff;
  logic [7:0] nxt_fire;
  logic [7:0] pulse;
  // A held request still gives a single strobe, as a real source does
  always_comb begin
    nxt_fire = aresetn ? fire_req : 8'h00;
    pulse    = fire_req & ~fire_ff;
  end
  always_ff @(posedge aclk) begin
    fire_ff <= nxt_fire;
  end
  assign req0_events = pulse[7:6];
  assign req1_events = pulse[5:0];
endmodule
`default_nettype wire

// file: verif/test_peripheral_irq_enable_flag_bank.sv
// Self-checking bench for the peripheral interrupt flag bank
`timescale 1ns/100ps
`default_nettype none
module test_peripheral_irq_enable_flag_bank;
  import irq_bank_pkg::*;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_BAD = 12'h020;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, periph_irq_req;
  logic uart_rx_nonempty_flag, uart_tx_empty_flag;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, e0, e1;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  per_pin_change_flags, request3_flags, request4_flags;
  logic [7:0]  enable0_bits, enable1_bits, fire_req;
  req0_evt_s   req0_events;
  req1_evt_s   req1_events;
  enable3_s    enable3_out;
  enable4_s    enable4_out;
  int          num_errors = 0;
  int          cmp_count = 0;
  logic [11:0] offs [5] = '{OFF_ENABLE_3, OFF_ENABLE_4, OFF_REQUEST_0,
                            OFF_REQUEST_1, OFF_CONTROL};

  peripheral_irq_enable_flag_bank #(.ADDR_W(ADDR_W), .PIN_CHANGE_W(8)) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .req0_events, .req1_events, .per_pin_change_flags, .uart_rx_nonempty_flag,
    .uart_tx_empty_flag, .request3_flags, .request4_flags, .enable0_bits,
    .enable1_bits, .enable3_out, .enable4_out, .periph_irq_req);
  irq_event_source_model u_src (.aclk, .aresetn, .fire_req, .req0_events,
    .req1_events);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // No local limit: only the watchdog ends a wait for the answer
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, exp);
    check({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er});
  endtask
  task automatic do_reset;
    aresetn <= 1'b0;
    tick(12);
    aresetn <= 1'b1;
    tick(2);
  endtask
  task automatic irq_is(input logic exp);
    tick(3);
    check({31'h0, periph_irq_req}, {31'h0, exp});
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    test_done();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, uart_rx_nonempty_flag} = 3'h0;
    uart_tx_empty_flag = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hF;
    {per_pin_change_flags, request3_flags, request4_flags} = 24'h0;
    {enable0_bits, enable1_bits, fire_req} = 24'h0;
    do_reset();
    foreach (offs[i]) rd(offs[i], 32'h0, RESP_OKAY);
    rd(OFF_BAD, 32'h0, RESP_SLVERR);
    wr(OFF_BAD, 32'hFF, RESP_SLVERR);
    $display("Test reset and unmapped done");
    wr(OFF_ENABLE_3, 32'hA5, RESP_OKAY);
    wr(OFF_ENABLE_4, 32'h5A, RESP_OKAY);
    rd(OFF_ENABLE_3, 32'hA5, RESP_OKAY);
    rd(OFF_ENABLE_4, 32'h5A, RESP_OKAY);
    check({31'h0, enable3_out.osc_fail_irq_en}, 32'h1);
    check({31'h0, enable4_out.wavegen1_irq_en}, 32'h1);
    check({31'h0, enable4_out.capcomp1_irq_en}, 32'h0);
    $display("Test enable registers done");
    wr(OFF_REQUEST_0, 32'hFF, RESP_OKAY);
    rd(OFF_REQUEST_0, 32'h21, RESP_OKAY);
    wr(OFF_REQUEST_0, 32'h00, RESP_OKAY);
    per_pin_change_flags <= 8'h10;
    wr(OFF_REQUEST_0, 32'h00, RESP_OKAY);
    rd(OFF_REQUEST_0, 32'h10, RESP_OKAY);
    per_pin_change_flags <= 8'h00;
    rd(OFF_REQUEST_0, 32'h00, RESP_OKAY);
    $display("Test request 0 layout done");
    // Request enables and control still zero: flags must set regardless
    for (int i = 0; i < 8; i++) begin
      fire_req <= 8'h01 << i;
      tick(1);
      fire_req <= 8'h00;
      e0 = (i == 7) ? 32'h20 : (i == 6) ? 32'h01 : 32'h0;
      e1 = (i < 6) ? 32'h1 << ((i < 4) ? i : i + 2) : 32'h0;
      rd(OFF_REQUEST_0, e0, RESP_OKAY);
      rd(OFF_REQUEST_1, e1, RESP_OKAY);
      wr(OFF_REQUEST_0, 32'h00, RESP_OKAY);
      wr(OFF_REQUEST_1, 32'h00, RESP_OKAY);
    end
    uart_rx_nonempty_flag <= 1'b1;
    rd(OFF_REQUEST_1, 32'h20, RESP_OKAY);
    uart_rx_nonempty_flag <= 1'b0;
    uart_tx_empty_flag <= 1'b1;
    rd(OFF_REQUEST_1, 32'h10, RESP_OKAY);
    uart_tx_empty_flag <= 1'b0;
    $display("Test event flags done");
    enable1_bits <= 8'h01;
    fire_req <= 8'h01;
    tick(1);
    fire_req <= 8'h00;
    irq_is(1'b0);
    wr(OFF_CONTROL, 32'h80, RESP_OKAY);
    irq_is(1'b0);
    wr(OFF_CONTROL, 32'hC0, RESP_OKAY);
    irq_is(1'b1);
    enable1_bits <= 8'h00;
    irq_is(1'b0);
    request3_flags <= 8'h01;
    irq_is(1'b1);
    request3_flags <= 8'h02;
    irq_is(1'b0);
    request3_flags <= 8'h00;
    request4_flags <= 8'h02;
    irq_is(1'b1);
    request4_flags <= 8'h01;
    irq_is(1'b0);
    $display("Test request gating done");
    fork
      wr(OFF_REQUEST_1, 32'h00, RESP_OKAY);
      begin
        // Pulse lands on the edge at which the clearing write commits
        do @(posedge aclk); while (!(s_axi_awvalid && s_axi_awready));
        fire_req <= 8'h01;
        tick(1);
        fire_req <= 8'h00;
      end
    join
    rd(OFF_REQUEST_1, 32'h01, RESP_OKAY);
    wr(OFF_REQUEST_1, 32'h00, RESP_OKAY);
    rd(OFF_REQUEST_1, 32'h00, RESP_OKAY);
    $display("Test set against clear done");
    do_reset();
    rd(OFF_ENABLE_3, 32'h0, RESP_OKAY);
    rd(OFF_CONTROL, 32'h0, RESP_OKAY);
    check({24'h0, enable3_out}, 32'h0);
    $display("Test second reset done");
    test_done();
  end
endmodule

bind peripheral_irq_enable_flag_bank irq_bank_checker #(.ADDR_W(ADDR_W)) u_chk (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .enable3_out, .enable4_out,
  .periph_irq_req);
`default_nettype wire
